// File: hdl/edge_detect.sv
// Rising edge finder for the trigger flag
`timescale 1ns/1ps
module edge_detect
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic level,
  output logic rise
);
  logic level_r;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      level_r <= 1'b0;
    else
      level_r <= level;
  end
  assign rise = level & ~level_r;
endmodule

// File: hdl/read_cycle_defs.svh
// Constants for the read cycle trigger handshake
`ifndef READ_CYCLE_DEFS_SVH
`define READ_CYCLE_DEFS_SVH
`define IN_INSTANCE 100
`define OUT_INSTANCE 197
`define RPI_MIN_US 8000
`define RPI_MAX_US 65000
`define RPI_DEF_US 20000
`define CLOCK_MHZ 25
`define TAG_W 16
`define CAPTURES_DEF 2
`define REG_ADDR_W 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_IRQ_STAT 4'h2
`define REG_IRQ_MASK 4'h3
`define REG_CYCLE_TAG 4'h4
`define REG_RESULT_TAG 4'h5
`define REG_COUNTS 4'h6
`define REG_LENGTH 4'h7
`define IRQ_START 0
`define IRQ_DECODE 1
`define IRQ_DONE 2
`define IRQ_W 3
`endif

// File: hdl/read_cycle_pkg.sv
// Types for the read cycle trigger handshake
`include "read_cycle_defs.svh"
package read_cycle_pkg;
  typedef logic [`TAG_W-1:0] tag_t;
  typedef struct packed
  {
    logic trigger_seen_bit;
    logic capture_done;
    logic trigger_ready;
    logic cycle_passed;
    tag_t cycle_tag;
    tag_t result_tag;
  } in_assembly_s;
  typedef struct packed
  {
    logic capture_start;
    logic capture_end;
    logic decode_start;
    logic cycle_end;
    logic cycle_ok;
  } engine_s;
  typedef enum logic [2:0] {IDLE, CAPTURE, GAP, FINISH} phase_e;
endpackage

// File: hdl/read_cycle_trigger_handshake.sv
// Device side trigger and report handshake of the code reader
`timescale 1ns/1ps
`include "read_cycle_defs.svh"
module read_cycle_trigger_handshake
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic trigger,
  input wire read_cycle_pkg::engine_s engine,
  input wire logic [`REG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output read_cycle_pkg::in_assembly_s status,
  output logic capture_go,
  output logic irq
);
  import read_cycle_pkg::*;

  logic trig_rise;
  logic tag_step;
  tag_t next_tag;
  phase_e phase_r;
  logic seen_r;
  logic done_r;
  logic ready_r;
  logic passed_r;
  tag_t cycle_r;
  tag_t result_r;
  logic go_r;
  logic enable_r;
  logic [7:0] captures_r;
  logic [7:0] taken_r;
  logic decoding_r;
  logic [`IRQ_W-1:0] irq_stat_r;
  logic [`IRQ_W-1:0] irq_mask_r;
  logic [`IRQ_W-1:0] irq_evt;
  logic [31:0] rdata_r;
  logic irq_r;
  logic start_go;
  logic [15:0] good_r;
  logic [15:0] fail_r;
  logic [15:0] span_r;
  logic [15:0] length_r;

  // One past the captures already taken
  function automatic logic [7:0] bump(input logic [7:0] v);
    bump = v + 8'h01;
  endfunction

  // Write decode shared by every writable register
  function automatic logic write_hit
  (
    input logic wr,
    input logic [`REG_ADDR_W-1:0] at,
    input logic [`REG_ADDR_W-1:0] want
  );
    write_hit = wr && (at == want);
  endfunction

  // Triggers while disabled or busy are dropped, not queued
  assign start_go = (phase_r == IDLE) && trig_rise && enable_r;

  edge_detect u_edge
  (
    .clock(clock),
    .rst_n(rst_n),
    .level(trigger),
    .rise(trig_rise)
  );

  // New tag only on the first decode of a cycle
  assign tag_step = engine.decode_start & ~decoding_r;

  tag_counter #(.W(`TAG_W)) u_tag
  (
    .clock(clock),
    .rst_n(rst_n),
    .step(tag_step),
    .tag(next_tag)
  );

  // Trigger seen mirrors sampled trigger level
  // Sampled every clock, far inside any packet interval
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      seen_r <= 1'b0;
    else
      seen_r <= trigger;
  end

  // Capture sequencer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r <= IDLE;
      taken_r <= 8'h00;
      go_r <= 1'b0;
    end
    else
    begin
      go_r <= 1'b0;
      case (phase_r)
        IDLE:
        begin
          if (start_go)
          begin
            phase_r <= CAPTURE;
            taken_r <= 8'h00;
            go_r <= 1'b1;
          end
        end
        CAPTURE:
        begin
          if (engine.capture_end)
          begin
            taken_r <= bump(taken_r);
            if (bump(taken_r) >= captures_r)
              phase_r <= FINISH;
            else
              phase_r <= GAP;
          end
        end
        GAP:
        begin
          if (engine.capture_start)
            phase_r <= CAPTURE;
        end
        FINISH:
          phase_r <= IDLE;
        default:
          phase_r <= IDLE;
      endcase
    end
  end

  // Capture done and trigger ready flags
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_r <= 1'b1;
      ready_r <= 1'b1;
    end
    else if (start_go)
    begin
      done_r <= 1'b0;
      ready_r <= 1'b0;
    end
    else if (phase_r == GAP && engine.capture_start)
    begin
      done_r <= 1'b0;
      ready_r <= 1'b0;
    end
    else if (phase_r == GAP || phase_r == FINISH)
    begin
      done_r <= 1'b1;
      ready_r <= 1'b1;
    end
  end

  // Cycle tag, result tag and pass flag
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      decoding_r <= 1'b0;
      cycle_r <= '0;
      result_r <= '0;
      passed_r <= 1'b0;
    end
    else
    begin
      if (tag_step)
      begin
        decoding_r <= 1'b1;
        cycle_r <= next_tag + {{(`TAG_W-1){1'b0}}, 1'b1};
      end
      if (engine.cycle_end)
      begin
        decoding_r <= 1'b0;
        // Report written in the same cycle as the tag: both stable together
        result_r <= cycle_r;
        passed_r <= engine.cycle_ok;
      end
    end
  end

  // Report counters wrap; software takes differences
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      good_r <= '0;
      fail_r <= '0;
    end
    else if (engine.cycle_end)
    begin
      if (engine.cycle_ok)
        good_r <= good_r + 16'h0001;
      else
        fail_r <= fail_r + 16'h0001;
    end
  end

  // Clocks from capture start to FINISH, GAP phases included, saturating so a stall never wraps
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      span_r <= '0;
      length_r <= '0;
    end
    else if (start_go)
      span_r <= 16'h0001;
    else if (phase_r == FINISH)
      length_r <= span_r;
    else if (phase_r != IDLE && span_r != 16'hffff)
      span_r <= span_r + 16'h0001;
  end

  assign irq_evt = {engine.cycle_end, tag_step, go_r};

  // Register writes and sticky interrupt bits
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_r <= 1'b1;
      captures_r <= 8'(`CAPTURES_DEF);
      irq_mask_r <= '0;
      irq_stat_r <= '0;
    end
    else
    begin
      if (write_hit(reg_write, reg_addr, `REG_CTRL))
      begin
        enable_r <= reg_wdata[0];
        captures_r <= (reg_wdata[15:8] == 8'h00) ? 8'h01 : reg_wdata[15:8];
      end
      if (write_hit(reg_write, reg_addr, `REG_IRQ_MASK))
        irq_mask_r <= reg_wdata[`IRQ_W-1:0];
      // Set wins over a clear in the same cycle
      if (write_hit(reg_write, reg_addr, `REG_IRQ_STAT))
        irq_stat_r <= (irq_stat_r & ~reg_wdata[`IRQ_W-1:0]) | irq_evt;
      else
        irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0;
    else if (reg_read)
    begin
      case (reg_addr)
        `REG_CTRL: rdata_r <= {16'h0, captures_r, 7'h0, enable_r};
        `REG_STATUS: rdata_r <= {26'h0, phase_r, passed_r, ready_r, done_r};
        `REG_IRQ_STAT: rdata_r <= {29'h0, irq_stat_r};
        `REG_IRQ_MASK: rdata_r <= {29'h0, irq_mask_r};
        `REG_CYCLE_TAG: rdata_r <= {16'h0, cycle_r};
        `REG_RESULT_TAG: rdata_r <= {16'h0, result_r};
        `REG_COUNTS: rdata_r <= {fail_r, good_r};
        `REG_LENGTH: rdata_r <= {16'h0, length_r};
        default: rdata_r <= 32'h0;
      endcase
    end
    else
      rdata_r <= 32'h0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_stat_r & irq_mask_r);
  end

  assign reg_rdata = rdata_r;
  assign capture_go = go_r;
  assign irq = irq_r;
  assign status = '{seen_r, done_r, ready_r, passed_r, cycle_r, result_r};
endmodule

// File: hdl/tag_counter.sv
// Cycle tag generator, never repeats the previous value
`timescale 1ns/1ps
module tag_counter #(parameter int W = 16)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic step,
  output logic [W-1:0] tag
);
  logic [W-1:0] tag_r;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tag_r <= '0;
    else if (step)
      tag_r <= tag_r + {{(W-1){1'b0}}, 1'b1};
  end
  assign tag = tag_r;
endmodule

// File: tb/plc_model.sv
// Controller model: triggers on request, counts reports
`timescale 1ns/1ps
`include "read_cycle_defs.svh"
module plc_model
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [1:0] operating_state_field,
  input wire read_cycle_pkg::in_assembly_s status,
  output logic trigger,
  output logic [7:0] good_n,
  output logic [7:0] ng_n
);
  import read_cycle_pkg::*;
  logic pend_r;
  tag_t cyc_old_r;
  tag_t res_old_r;
  // Assembly instances used when no description file is loaded
  localparam int in_instance = `IN_INSTANCE;
  localparam int out_instance = `OUT_INSTANCE;
  // Busy until new cycle tag, so one request gives one cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trigger <= 1'h0;
      pend_r <= 1'h0;
      cyc_old_r <= '0;
      res_old_r <= '0;
      good_n <= 8'h0;
      ng_n <= 8'h0;
    end
    else
    begin
      if (req && !pend_r && status.trigger_ready &&
          !status.trigger_seen_bit && operating_state_field > 2'h0)
      begin
        trigger <= 1'h1;
        pend_r <= 1'h1;
      end
      else if (trigger && status.trigger_seen_bit)
        trigger <= 1'h0;
      if (status.cycle_tag !== cyc_old_r)
      begin
        cyc_old_r <= status.cycle_tag;
        pend_r <= 1'h0;
      end
      if (status.result_tag !== res_old_r)
      begin
        res_old_r <= status.result_tag;
        if (status.cycle_passed)
          good_n <= good_n + 8'h1;
        else
          ng_n <= ng_n + 8'h1;
      end
    end
  end
endmodule

// File: tb/read_cycle_asserts.sv
// Port checker for the trigger handshake
`timescale 1ns/1ps
`include "read_cycle_defs.svh"
module read_cycle_asserts
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic trigger,
  input wire read_cycle_pkg::engine_s engine,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire read_cycle_pkg::in_assembly_s status,
  input wire logic capture_go
);
  import read_cycle_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_seen; status.trigger_seen_bit == $past(trigger); endproperty
  a_seen: assert property (p_seen) else $error("seen flag");
  property p_go; capture_go |-> $past(trigger) && !$past(trigger, 2);
  endproperty
  a_go: assert property (p_go) else $error("start without rise");
  property p_busy;
    capture_go |-> !status.capture_done && !status.trigger_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("flags high");
  property p_next;
    engine.capture_start |=> !status.capture_done && !status.trigger_ready;
  endproperty
  a_next: assert property (p_next) else $error("flags kept");
  property p_tag;
    status.cycle_tag != $past(status.cycle_tag) |-> $past(engine.decode_start);
  endproperty
  a_tag: assert property (p_tag) else $error("tag moved");
  property p_rep;
    engine.cycle_end |=> status.result_tag == $past(status.cycle_tag);
  endproperty
  a_rep: assert property (p_rep) else $error("result tag");
  property p_pass;
    engine.cycle_end |=> status.cycle_passed == $past(engine.cycle_ok);
  endproperty
  a_pass: assert property (p_pass) else $error("passed flag");
  property p_rd; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data idle");
endmodule
bind read_cycle_trigger_handshake read_cycle_asserts i_chk
(
  .clock(clock),
  .rst_n(rst_n),
  .trigger(trigger),
  .engine(engine),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .status(status),
  .capture_go(capture_go)
);

// File: tb/read_cycle_trigger_handshake_test.sv
// Self-checking bench for the trigger handshake
`timescale 1ns/1ps
module read_cycle_trigger_handshake_test;
  import read_cycle_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic req = 1'h0;
  logic [1:0] op_state = 2'h1;
  logic trigger;
  engine_s engine = '0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'h0;
  logic reg_read = 1'h0;
  logic [31:0] reg_rdata;
  in_assembly_s status;
  logic capture_go;
  logic irq;
  logic [7:0] good_n;
  logic [7:0] ng_n;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #20 clock = ~clock;
  read_cycle_trigger_handshake i_dut (.clock(clock), .rst_n(rst_n),
    .trigger(trigger), .engine(engine), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .status(status), .capture_go(capture_go),
    .irq(irq));
  plc_model i_plc (.clock(clock), .rst_n(rst_n), .req(req),
    .operating_state_field(op_state),
    .status(status), .trigger(trigger), .good_n(good_n), .ng_n(ng_n));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clock);
    reg_read <= 1'h0;
    @(negedge clock);
    chk(n, e, reg_rdata);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
    repeat (2) @(negedge clock);
  endtask
  // Extra settle cycle covers a flag registered from the phase
  task pulse(input logic [4:0] v);
    @(posedge clock);
    engine <= engine_s'(v);
    @(posedge clock);
    engine <= '0;
    repeat (2) @(negedge clock);
  endtask
  task flags(input logic [1:0] e);
    chk("flags", e, {status.capture_done, status.trigger_ready});
  endtask
  task run(input logic ok, input logic [15:0] t);
    @(posedge clock);
    req <= 1'h1;
    for (int i = 0; i < 40 && capture_go !== 1'h1; i++) @(negedge clock);
    chk("start", 1, capture_go);
    flags(2'h0);
    @(posedge clock);
    req <= 1'h0;
    pulse(5'h08);
    flags(2'h3);
    pulse(5'h10);
    flags(2'h0);
    pulse(5'h04);
    chk("cycle tag", t, status.cycle_tag);
    pulse(5'h08);
    flags(2'h3);
    pulse({4'h1, ok});
    chk("result tag", t, status.result_tag);
    chk("passed", ok, status.cycle_passed);
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    rd(4'h0, 32'h201, "ctrl");
    rd(4'h1, 32'h3, "status");
    rd(4'h3, 32'h0, "mask");
    rd(4'hf, 32'h0, "unmapped");
    rd(4'h6, 32'h0, "counts");
    $display("reset test done");
    run(1'h1, 16'h1);
    chk("good", 8'h1, good_n);
    rd(4'h6, 32'h1, "counts");
    rd(4'h7, 32'hd, "length");
    chk("irq masked", 0, irq);
    rd(4'h2, 32'h7, "irq stat");
    wr(4'h3, 32'h7);
    chk("irq on", 1, irq);
    wr(4'h2, 32'h7);
    chk("irq off", 0, irq);
    rd(4'h2, 32'h0, "irq cleared");
    $display("irq test done");
    run(1'h0, 16'h2);
    chk("no good", 8'h1, ng_n);
    rd(4'h6, 32'h10001, "counts");
    $display("fail cycle test done");
    @(posedge clock);
    op_state <= 2'h0;
    req <= 1'h1;
    repeat (10) @(negedge clock);
    chk("no trigger in stop", 0, trigger);
    $display("stop state test done");
    wr(4'h0, 32'h200);
    @(posedge clock);
    op_state <= 2'h1;
    req <= 1'h1;
    repeat (10) @(negedge clock);
    rd(4'h1, 32'h3, "disabled idle");
    $display("disable test done");
    tally_and_finish;
  end
endmodule
